//--- dioc_consts.svh
`ifndef DIOC_CONSTS_SVH
`define DIOC_CONSTS_SVH

// clock rate
`define DIOC_CLK_MHZ 125

// register byte offsets
`define DIOC_OFS_CTRL 8'h00
`define DIOC_OFS_OPEN_EN 8'h04
`define DIOC_OFS_FAULT_ACT 8'h08
`define DIOC_OFS_IDLE_ACT 8'h0c
`define DIOC_OFS_CNT_EN 8'h10
`define DIOC_OFS_CNT_CLR 8'h14
`define DIOC_OFS_STATUS 8'h18
`define DIOC_OFS_IN_STATE 8'h1c
`define DIOC_OFS_THRESH 8'h20
`define DIOC_OFS_COUNT 8'h40

// control field positions
`define DIOC_CTRL_SHORT_EN 0
`define DIOC_CTRL_MANUAL 1
`define DIOC_CTRL_SUPPLY_EN 2
`define DIOC_CTRL_INRUSH_EN 3
`define DIOC_CTRL_SW_PRIO 4
`define DIOC_CTRL_FILT_LSB 8
`define DIOC_CTRL_EXT_LSB 12

// status field positions
`define DIOC_ST_SHORT_LSB 0
`define DIOC_ST_OPEN_LSB 8
`define DIOC_ST_CNT_LSB 16
`define DIOC_ST_SUPPLY 24
`define DIOC_ST_INRUSH 25

// reset values, threshold limit and count scale
`define DIOC_CTRL_RST 32'h0000_1100
`define DIOC_THRESH_RST 16'h0001
`define DIOC_THRESH_MAX 16'hfde8
`define DIOC_CNT_SCALE 1000

// times in their own units
`define DIOC_FILT_US0 100
`define DIOC_FILT_US1 1000
`define DIOC_FILT_US2 10000
`define DIOC_FILT_US3 20000
`define DIOC_EXT_US0 1000
`define DIOC_EXT_US1 15000
`define DIOC_EXT_US2 100000
`define DIOC_EXT_US3 200000
`define DIOC_INRUSH_MS 100
`define DIOC_SAVE_PERIOD_S 3600

`endif

//--- dioc_pkg.sv
`default_nettype none
package dioc_pkg;

	typedef enum logic [1:0] {
		act_clear                  = 2'h0,
		act_hold                   = 2'h1,
		act_assert_output_forcibly = 2'h2
	} dioc_act_type;

	typedef enum logic [1:0] {
		st_restore_read = 2'h0,
		st_restore_load = 2'h1,
		st_run          = 2'h2,
		st_save         = 2'h3
	} dioc_state_type;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} dioc_bus_req_type;

	typedef struct packed {
		logic comm_fault;
		logic comm_idle;
	} dioc_comm_type;

	typedef struct packed {
		logic [1:0] ext_sel;
		logic [1:0] filt_sel;
		logic       sw_prio;
		logic       inrush_en;
		logic       supply_en;
		logic       manual;
		logic       short_en;
	} dioc_ctrl_type;

endpackage : dioc_pkg
`default_nettype wire

//--- dioc_count_store.sv
`timescale 1ns/1ps
`default_nettype none
// no reset on the array: contents survive a reset like retained storage
module dioc_count_store #(
	parameter int W  = 32,
	parameter int D  = 8,
	parameter int AW = 3
) (
	// clock and reset
	input  wire logic          clk,
	input  wire logic          reset_n,
	// write port
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [W-1:0]  wr_data,
	// read port
	input  wire logic [AW-1:0] rd_addr,
	output var  logic [W-1:0]  rd_data
);
	// blank store at first power-up; a declaration value leaves always_ff the only writer
	logic [W-1:0] mem [D] = '{default: '0};

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rd_data <= '0;
		end else begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule : dioc_count_store
`default_nettype wire

//--- dioc_input_cond.sv
`timescale 1ns/1ps
`default_nettype none
module dioc_input_cond #(
	parameter int CW = 25
) (
	// clock and reset
	input  wire logic          clk,
	input  wire logic          reset_n,
	// synchronised input and selected times
	input  wire logic          raw,
	input  wire logic [CW-1:0] filt_cyc,
	input  wire logic [CW-1:0] ext_cyc,
	// conditioned state
	output var  logic          state
);
	logic          filt;
	logic [CW-1:0] fcnt;
	logic [CW-1:0] hcnt;

	// a change must persist for the whole filter time
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			filt <= 1'b0;
			fcnt <= '0;
		end else if (raw == filt) begin
			fcnt <= '0;
		end else if (fcnt + 1'b1 >= filt_cyc) begin
			filt <= raw;
			fcnt <= '0;
		end else begin
			fcnt <= fcnt + 1'b1;
		end
	end

	// each accepted state is held at least the extension time
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state <= 1'b0;
			hcnt  <= '0;
		end else if (hcnt != '0) begin
			hcnt <= hcnt - 1'b1;
		end else if (filt != state) begin
			state <= filt;
			hcnt  <= ext_cyc;
		end
	end
endmodule : dioc_input_cond
`default_nettype wire

//--- dioc_supervisor.sv
// Functional notes
// - short detection enable raises load short error
// - auto restart clears error once short gone
// - manual restart latches error until reset or until short detection is disabled
// - per-channel open detection raises open error
// - communication fault applies channel fault action
// - communication idle applies channel idle action
// - channel actions only under software priority
// - count transitions, error above threshold times 1000
// - save counts hourly, resume after power-up
// - inrush filter masks overcurrent for 100 ms
// - ignore input pulses shorter than filter time
// - stretch input states for extension time
// - supply short detection raises supply error
`timescale 1ns/1ps
`default_nettype none
`include "dioc_consts.svh"
module dioc_supervisor #(
	parameter int                  NCH        = 8,
	parameter logic [3:0][24:0]    FILT_CYC   = {25'(`DIOC_FILT_US3 * `DIOC_CLK_MHZ),
		25'(`DIOC_FILT_US2 * `DIOC_CLK_MHZ), 25'(`DIOC_FILT_US1 * `DIOC_CLK_MHZ),
		25'(`DIOC_FILT_US0 * `DIOC_CLK_MHZ)},
	parameter logic [3:0][24:0]    EXT_CYC    = {25'(`DIOC_EXT_US3 * `DIOC_CLK_MHZ),
		25'(`DIOC_EXT_US2 * `DIOC_CLK_MHZ), 25'(`DIOC_EXT_US1 * `DIOC_CLK_MHZ),
		25'(`DIOC_EXT_US0 * `DIOC_CLK_MHZ)},
	parameter logic [24:0]         INRUSH_CYC = 25'(`DIOC_INRUSH_MS * 1000 * `DIOC_CLK_MHZ),
	parameter logic [63:0]         SAVE_CYC   = 64'(`DIOC_SAVE_PERIOD_S) * 64'd1000000 * 64'(`DIOC_CLK_MHZ)
) (
	// clock and reset
	input  wire logic                      clk,
	input  wire logic                      reset_n,
	// register port
	input  wire dioc_pkg::dioc_bus_req_type bus,
	output var  logic [31:0]               rdata,
	// controller side
	input  wire dioc_pkg::dioc_comm_type   comm,
	input  wire logic [NCH-1:0]            out_cmd,
	// field pins
	input  wire logic [NCH-1:0]            load_short_pin,
	input  wire logic [NCH-1:0]            load_open_pin,
	input  wire logic                      supply_short_pin,
	input  wire logic [NCH-1:0]            din_pin,
	// outputs
	output var  logic [NCH-1:0]            dout,
	output var  logic [NCH-1:0]            din_state,
	output var  logic                      err_any
);
	localparam int IW = (NCH > 1) ? $clog2(NCH) : 1;

	dioc_pkg::dioc_ctrl_type  ctrl;
	dioc_pkg::dioc_state_type state;
	logic [NCH-1:0]   open_en;
	logic [NCH-1:0]   cnt_en;
	logic [2*NCH-1:0] fault_act;
	logic [2*NCH-1:0] idle_act;
	logic [15:0]      thresh [NCH];
	logic [31:0]      count [NCH];
	logic [NCH-1:0]   cnt_clr;
	logic [NCH-1:0]   short_err;
	logic [NCH-1:0]   open_err;
	logic [NCH-1:0]   cnt_err;
	logic             supply_err;
	logic [NCH-1:0]   next_dout;
	logic [NCH-1:0]   toggled;
	logic [24:0]      inrush_cnt;
	logic             inrush_mask;
	logic [63:0]      save_timer;
	logic             save_tick;
	logic [IW-1:0]    idx;
	logic [31:0]      store_rd;
	logic [31:0]      status;
	logic [31:0]      next_rdata;
	logic [IW-1:0]    bus_ch;

	// pin synchronisers
	logic [NCH-1:0] short_s1, short_s2, open_s1, open_s2, din_s1, din_s2;
	logic           supply_s1, supply_s2;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			short_s1  <= '0;
			short_s2  <= '0;
			open_s1   <= '0;
			open_s2   <= '0;
			din_s1    <= '0;
			din_s2    <= '0;
			supply_s1 <= 1'b0;
			supply_s2 <= 1'b0;
		end else begin
			short_s1  <= load_short_pin;
			short_s2  <= short_s1;
			open_s1   <= load_open_pin;
			open_s2   <= open_s1;
			din_s1    <= din_pin;
			din_s2    <= din_s1;
			supply_s1 <= supply_short_pin;
			supply_s2 <= supply_s1;
		end
	end

	function automatic logic in_blk(input logic [7:0] addr, input logic [7:0] base);
		return addr[7:5] == base[7:5];
	endfunction : in_blk

	function automatic logic act_value(input logic [1:0] act, input logic held);
		logic v;
		case (dioc_pkg::dioc_act_type'(act))
			dioc_pkg::act_hold:                   v = held;
			dioc_pkg::act_assert_output_forcibly: v = 1'b1;
			default:                              v = 1'b0;
		endcase
		return v;
	endfunction : act_value

	// register word to control fields; reset and write share it so both follow the map
	function automatic dioc_pkg::dioc_ctrl_type ctrl_of(input logic [31:0] w);
		dioc_pkg::dioc_ctrl_type c;
		c.short_en  = w[`DIOC_CTRL_SHORT_EN];
		c.manual    = w[`DIOC_CTRL_MANUAL];
		c.supply_en = w[`DIOC_CTRL_SUPPLY_EN];
		c.inrush_en = w[`DIOC_CTRL_INRUSH_EN];
		c.sw_prio   = w[`DIOC_CTRL_SW_PRIO];
		c.filt_sel  = w[`DIOC_CTRL_FILT_LSB +: 2];
		c.ext_sel   = w[`DIOC_CTRL_EXT_LSB +: 2];
		return c;
	endfunction : ctrl_of

	assign bus_ch = bus.addr[IW+1:2];

	// register writes
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ctrl      <= ctrl_of(`DIOC_CTRL_RST);
			open_en   <= '0;
			cnt_en    <= '0;
			fault_act <= '0;
			idle_act  <= '0;
		end else if (bus.wr) begin
			case (bus.addr)
				`DIOC_OFS_CTRL:      ctrl      <= ctrl_of(bus.wdata);
				`DIOC_OFS_OPEN_EN:   open_en   <= bus.wdata[NCH-1:0];
				`DIOC_OFS_FAULT_ACT: fault_act <= bus.wdata[2*NCH-1:0];
				`DIOC_OFS_IDLE_ACT:  idle_act  <= bus.wdata[2*NCH-1:0];
				`DIOC_OFS_CNT_EN:    cnt_en    <= bus.wdata[NCH-1:0];
				default: ;
			endcase
		end
	end

	// thresholds kept inside the settable range
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			for (int i = 0; i < NCH; i++) begin
				thresh[i] <= `DIOC_THRESH_RST;
			end
		end else if (bus.wr && in_blk(bus.addr, `DIOC_OFS_THRESH) && 32'(bus_ch) < NCH) begin
			if (bus.wdata[31:16] != 16'h0 || bus.wdata[15:0] > `DIOC_THRESH_MAX) begin
				thresh[bus_ch] <= `DIOC_THRESH_MAX;
			end else if (bus.wdata[15:0] == 16'h0) begin
				thresh[bus_ch] <= `DIOC_THRESH_RST;
			end else begin
				thresh[bus_ch] <= bus.wdata[15:0];
			end
		end
	end

	assign cnt_clr = (bus.wr && bus.addr == `DIOC_OFS_CNT_CLR) ? bus.wdata[NCH-1:0] : '0;

	// output selection
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			if (comm.comm_fault) begin
				next_dout[i] = ctrl.sw_prio ? act_value(fault_act[2*i +: 2], dout[i]) : 1'b0;
			end else if (comm.comm_idle) begin
				next_dout[i] = ctrl.sw_prio ? act_value(idle_act[2*i +: 2], dout[i]) : 1'b0;
			end else begin
				next_dout[i] = out_cmd[i];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			dout <= '0;
		end else begin
			dout <= next_dout;
		end
	end

	assign toggled = next_dout ^ dout;

	// inrush window runs from the end of reset
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			inrush_cnt <= INRUSH_CYC;
		end else if (inrush_cnt != 25'h0) begin
			inrush_cnt <= inrush_cnt - 25'h1;
		end
	end

	assign inrush_mask = ctrl.inrush_en && inrush_cnt != 25'h0;

	// short errors: a new short wins over the auto clear
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			short_err <= '0;
		end else if (!ctrl.short_en) begin
			short_err <= '0;
		end else begin
			short_err <= (short_s2 & ~{NCH{inrush_mask}}) | (ctrl.manual ? short_err : '0);
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			open_err   <= '0;
			supply_err <= 1'b0;
		end else begin
			open_err   <= open_en & open_s2;
			supply_err <= ctrl.supply_en & supply_s2;
		end
	end

	// transition counters; restore and hourly save via the store
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			for (int i = 0; i < NCH; i++) begin
				count[i] <= '0;
			end
		end else begin
			for (int i = 0; i < NCH; i++) begin
				if (state == dioc_pkg::st_restore_load && 32'(idx) == i) begin
					count[i] <= store_rd;
				end else if (state != dioc_pkg::st_restore_read && state != dioc_pkg::st_restore_load) begin
					if (cnt_clr[i]) begin
						count[i] <= {31'h0, toggled[i]};
					end else if (toggled[i] && count[i] != 32'hffff_ffff) begin
						count[i] <= count[i] + 32'h1;
					end
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cnt_err <= '0;
		end else begin
			for (int i = 0; i < NCH; i++) begin
				cnt_err[i] <= cnt_en[i] && count[i] > 32'(thresh[i]) * 32'(`DIOC_CNT_SCALE);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			save_timer <= '0;
		end else if (save_timer >= SAVE_CYC - 64'h1) begin
			save_timer <= '0;
		end else begin
			save_timer <= save_timer + 64'h1;
		end
	end

	assign save_tick = save_timer >= SAVE_CYC - 64'h1;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state <= dioc_pkg::st_restore_read;
			idx   <= '0;
		end else begin
			case (state)
				dioc_pkg::st_restore_read: state <= dioc_pkg::st_restore_load;
				dioc_pkg::st_restore_load: begin
					if (32'(idx) == NCH - 1) begin
						state <= dioc_pkg::st_run;
						idx   <= '0;
					end else begin
						state <= dioc_pkg::st_restore_read;
						idx   <= idx + 1'b1;
					end
				end
				dioc_pkg::st_run: begin
					if (save_tick) begin
						state <= dioc_pkg::st_save;
						idx   <= '0;
					end
				end
				dioc_pkg::st_save: begin
					if (32'(idx) == NCH - 1) begin
						state <= dioc_pkg::st_run;
						idx   <= '0;
					end else begin
						idx <= idx + 1'b1;
					end
				end
				default: state <= dioc_pkg::st_run;
			endcase
		end
	end

	dioc_count_store #(
		.W  (32),
		.D  (NCH),
		.AW (IW)
	) u_store (
		.clk     (clk),
		.reset_n (reset_n),
		.wr_en   (state == dioc_pkg::st_save),
		.wr_addr (idx),
		.wr_data (count[idx]),
		.rd_addr (idx),
		.rd_data (store_rd)
	);

	// input conditioning per channel
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_in
			dioc_input_cond #(
				.CW (25)
			) u_cond (
				.clk      (clk),
				.reset_n  (reset_n),
				.raw      (din_s2[g]),
				.filt_cyc (FILT_CYC[ctrl.filt_sel]),
				.ext_cyc  (EXT_CYC[ctrl.ext_sel]),
				.state    (din_state[g])
			);
		end
	endgenerate

	// register reads, data in the following cycle
	always_comb begin
		status = '0;
		status[`DIOC_ST_SHORT_LSB +: NCH] = short_err;
		status[`DIOC_ST_OPEN_LSB +: NCH]  = open_err;
		status[`DIOC_ST_CNT_LSB +: NCH]   = cnt_err;
		status[`DIOC_ST_SUPPLY]           = supply_err;
		status[`DIOC_ST_INRUSH]           = inrush_mask;
		next_rdata = '0;
		if (in_blk(bus.addr, `DIOC_OFS_THRESH) && 32'(bus_ch) < NCH) begin
			next_rdata[15:0] = thresh[bus_ch];
		end else if (in_blk(bus.addr, `DIOC_OFS_COUNT) && 32'(bus_ch) < NCH) begin
			next_rdata = count[bus_ch];
		end else begin
			case (bus.addr)
				`DIOC_OFS_CTRL: begin
					next_rdata[`DIOC_CTRL_SHORT_EN]      = ctrl.short_en;
					next_rdata[`DIOC_CTRL_MANUAL]        = ctrl.manual;
					next_rdata[`DIOC_CTRL_SUPPLY_EN]     = ctrl.supply_en;
					next_rdata[`DIOC_CTRL_INRUSH_EN]     = ctrl.inrush_en;
					next_rdata[`DIOC_CTRL_SW_PRIO]       = ctrl.sw_prio;
					next_rdata[`DIOC_CTRL_FILT_LSB +: 2] = ctrl.filt_sel;
					next_rdata[`DIOC_CTRL_EXT_LSB +: 2]  = ctrl.ext_sel;
				end
				`DIOC_OFS_OPEN_EN:   next_rdata[NCH-1:0]   = open_en;
				`DIOC_OFS_FAULT_ACT: next_rdata[2*NCH-1:0] = fault_act;
				`DIOC_OFS_IDLE_ACT:  next_rdata[2*NCH-1:0] = idle_act;
				`DIOC_OFS_CNT_EN:    next_rdata[NCH-1:0]   = cnt_en;
				`DIOC_OFS_STATUS:    next_rdata            = status;
				`DIOC_OFS_IN_STATE:  next_rdata[NCH-1:0]   = din_state;
				default:             next_rdata            = '0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rdata <= '0;
		end else begin
			rdata <= bus.rd ? next_rdata : '0;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			err_any <= 1'b0;
		end else begin
			err_any <= |{short_err, open_err, cnt_err, supply_err};
		end
	end
endmodule : dioc_supervisor
`default_nettype wire

//--- dioc_supervisor_properties.sv
`timescale 1ns/1ps
`default_nettype none
module dioc_supervisor_properties #(
	parameter int NCH = 8
) (
	// clock and reset
	input wire logic                       clk,
	input wire logic                       reset_n,
	// register port
	input wire dioc_pkg::dioc_bus_req_type bus,
	input wire logic [31:0]                rdata,
	// controller side
	input wire dioc_pkg::dioc_comm_type    comm,
	input wire logic [NCH-1:0]             out_cmd,
	// field pins
	input wire logic [NCH-1:0]             load_short_pin,
	input wire logic [NCH-1:0]             load_open_pin,
	input wire logic                       supply_short_pin,
	input wire logic [NCH-1:0]             din_pin,
	// outputs
	input wire logic [NCH-1:0]             dout,
	input wire logic [NCH-1:0]             din_state,
	input wire logic                       err_any
);
	logic [31:0]    ctrl, fact, iact, open_en, cnt_en;
	logic [NCH-1:0] exp_out;
	logic [1:0]     act;
	logic           quiet;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	// settings snooped from the bus, same edge as the design takes them
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ctrl <= 32'h0000_1100;
			{fact, iact, open_en, cnt_en} <= '0;
		end else if (bus.wr) begin
			case (bus.addr)
				8'h00: ctrl <= bus.wdata;
				8'h04: open_en <= bus.wdata;
				8'h08: fact <= bus.wdata;
				8'h0c: iact <= bus.wdata;
				8'h10: cnt_en <= bus.wdata;
				default: ;
			endcase
		end
	end

	// manual mode with short detection on counts as never quiet: a latch may be pending
	always_comb begin
		quiet = !(ctrl[0] && (ctrl[1] || |load_short_pin)) && !(ctrl[2] && supply_short_pin)
			&& !(|(open_en[NCH-1:0] & load_open_pin)) && cnt_en[NCH-1:0] == '0;
		for (int i = 0; i < NCH; i++) begin
			act = comm.comm_fault ? fact[2*i+:2] : iact[2*i+:2];
			if (!comm.comm_fault && !comm.comm_idle)
				exp_out[i] = out_cmd[i];
			else if (!ctrl[4] || act == 2'h0 || act == 2'h3)
				exp_out[i] = 1'b0;
			else
				exp_out[i] = (act == 2'h2) | dout[i];
		end
	end

	out_normal_a: assert property (reset_n && !comm.comm_fault && !comm.comm_idle |=> dout == $past(exp_out))
		else $error("dout not following command");
	out_fault_a: assert property (reset_n && comm.comm_fault |=> dout == $past(exp_out))
		else $error("wrong fault output");
	out_idle_a: assert property (reset_n && comm.comm_idle && !comm.comm_fault |=> dout == $past(exp_out))
		else $error("wrong idle output");
	// pin to err_any takes four edges, so five samples are needed
	err_quiet_a: assert property ((reset_n && quiet)[*5] |-> !err_any)
		else $error("error without enabled cause");
	short_err_a: assert property ((reset_n && ctrl[0] && !ctrl[3] && |load_short_pin)[*5] |-> err_any)
		else $error("load short not reported");
	manual_latch_a: assert property ((reset_n && ctrl[1:0] == 2'h3 && !ctrl[3] && |load_short_pin)[*4] ##1
		(reset_n && ctrl[1:0] == 2'h3)[*8] |-> err_any) else $error("manual short error released");
	open_err_a: assert property ((reset_n && |(open_en[NCH-1:0] & load_open_pin))[*5] |-> err_any)
		else $error("open load not reported");
	supply_err_a: assert property ((reset_n && ctrl[2] && supply_short_pin)[*5] |-> err_any)
		else $error("supply short not reported");
	ext_hold_a: assert property (reset_n && $changed(din_state[0]) |=> $stable(din_state[0])[*7])
		else $error("input state not stretched");

	cover property (comm.comm_fault && ctrl[4]);
	cover property ($rose(err_any));
	cover property (ctrl[1:0] == 2'h3 && err_any && !(|load_short_pin));
	cover property ($changed(din_state[0]));
endmodule : dioc_supervisor_properties

bind dioc_supervisor dioc_supervisor_properties #(.NCH(NCH)) u_props (.clk, .reset_n, .bus, .rdata, .comm,
	.out_cmd, .load_short_pin, .load_open_pin, .supply_short_pin, .din_pin, .dout, .din_state, .err_any);
`default_nettype wire

//--- dioc_field_model.sv
`timescale 1ns/1ps
`default_nettype none
module dioc_field_model #(
	parameter int NCH = 8
) (
	// drive and fault scenario
	input  wire logic [NCH-1:0] dout,
	input  wire logic [NCH-1:0] short_mask,
	input  wire logic [NCH-1:0] open_mask,
	// sensing pins
	output logic [NCH-1:0]      load_short_pin,
	output logic [NCH-1:0]      load_open_pin
);
	// a short only draws current while the channel drives
	assign load_short_pin = dout & short_mask;
	// leakage sensing sees a broken wire only while off
	assign load_open_pin = open_mask & ~dout;
endmodule : dioc_field_model
`default_nettype wire

//--- dioc_supervisor_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dioc_supervisor_tb;
	localparam int              NCH   = 8;
	localparam int              FT[4] = '{4, 8, 12, 16};
	localparam int              ET[4] = '{10, 20, 30, 40};
	logic                       clk = 1'b0;
	logic                       reset_n = 1'b0;
	dioc_pkg::dioc_bus_req_type bus = '0;
	dioc_pkg::dioc_comm_type    comm = '0;
	logic [NCH-1:0]             out_cmd = '0, short_mask = '0, open_mask = '0, din_pin = '0;
	logic                       supply_short_pin = 1'b0;
	logic [31:0]                rdata;
	logic [NCH-1:0]             load_short_pin, load_open_pin, dout, din_state;
	logic                       err_any;
	int                         n_fail = 0;
	int                         check_count = 0;

	always #4 clk = ~clk;

	dioc_supervisor #(.NCH(NCH), .FILT_CYC({25'd16, 25'd12, 25'd8, 25'd4}),
		.EXT_CYC({25'd40, 25'd30, 25'd20, 25'd10}), .INRUSH_CYC(25'd60), .SAVE_CYC(64'd50)
	) uut (.clk, .reset_n, .bus, .rdata, .comm, .out_cmd, .load_short_pin, .load_open_pin,
		.supply_short_pin, .din_pin, .dout, .din_state, .err_any);
	dioc_field_model #(.NCH(NCH)) field (.dout, .short_mask, .open_mask, .load_short_pin, .load_open_pin);

	task automatic results;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : results

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
			n_fail++;
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask : rd

	// bounded wait; a stuck flag ends the run
	task automatic wait_err(input logic v, input int n);
		#1;
		for (int k = 0; k < n && err_any !== v; k++)
			#8;
		chk(err_any, v);
		if (err_any !== v)
			results();
		@(posedge clk);
	endtask : wait_err

	task automatic do_reset;
		@(posedge clk);
		reset_n <= 1'b0;
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
	endtask : do_reset

	task automatic step(input logic [7:0] cmd, input logic f, input logic i, input logic [7:0] exp);
		@(posedge clk);
		out_cmd <= cmd;
		comm <= '{f, i};
		repeat (2) @(posedge clk);
		#1 chk(dout, exp);
	endtask : step

	task automatic t_outputs;
		rd(8'h00, 32'h0000_1100);
		wr(8'h00, 32'h0000_1110);
		wr(8'h08, 32'he4);
		wr(8'h0c, 32'h06);
		step(8'h0b, 1'b0, 1'b0, 8'h0b);
		step(8'h00, 1'b1, 1'b0, 8'h06);
		step(8'h00, 1'b0, 1'b1, 8'h03);
		step(8'h00, 1'b1, 1'b1, 8'h06);
		step(8'h00, 1'b0, 1'b0, 8'h00);
		wr(8'h00, 32'h0000_1100);
		step(8'hff, 1'b1, 1'b0, 8'h00);
		step(8'hff, 1'b0, 1'b1, 8'h00);
		step(8'hff, 1'b0, 1'b0, 8'hff);
		$display("test outputs done");
	endtask : t_outputs

	task automatic t_errors;
		do_reset;
		wr(8'h00, 32'h0000_1109);
		short_mask <= 8'h01;
		repeat (20) @(posedge clk);
		#1 chk(err_any, 1'b0);
		rd(8'h18, 32'h0200_0000);
		wait_err(1'b1, 60);
		short_mask <= 8'h00;
		wait_err(1'b0, 8);
		wr(8'h00, 32'h0000_1103);
		short_mask <= 8'h01;
		wait_err(1'b1, 8);
		short_mask <= 8'h00;
		repeat (10) @(posedge clk);
		rd(8'h18, 32'h0000_0001);
		do_reset;
		repeat (8) @(posedge clk);
		#1 chk(err_any, 1'b0);
		@(posedge clk);
		short_mask <= 8'h01;
		repeat (10) @(posedge clk);
		#1 chk(err_any, 1'b0);
		@(posedge clk);
		short_mask <= 8'h00;
		out_cmd <= 8'h00;
		open_mask <= 8'h06;
		wr(8'h04, 32'h04);
		wait_err(1'b1, 8);
		rd(8'h18, 32'h0000_0400);
		wr(8'h04, 32'h0);
		wait_err(1'b0, 8);
		supply_short_pin <= 1'b1;
		repeat (10) @(posedge clk);
		#1 chk(err_any, 1'b0);
		wr(8'h00, 32'h0000_1104);
		wait_err(1'b1, 8);
		rd(8'h18, 32'h0100_0000);
		@(posedge clk);
		supply_short_pin <= 1'b0;
		open_mask <= 8'h00;
		$display("test errors done");
	endtask : t_errors

	task automatic t_count;
		do_reset;
		repeat (2 * NCH + 2) @(posedge clk);
		rd(8'hfc, 32'h0);
		wr(8'h20, 32'h0);
		rd(8'h20, 32'h1);
		wr(8'h20, 32'h0000_ffff);
		rd(8'h20, 32'h0000_fde8);
		wr(8'h20, 32'h1);
		wr(8'h10, 32'h1);
		// the restore brings back earlier counts, so start from zero
		wr(8'h14, 32'h1);
		repeat (1000) begin
			@(posedge clk);
			out_cmd[0] <= ~out_cmd[0];
		end
		repeat (4) @(posedge clk);
		rd(8'h40, 32'd1000);
		rd(8'h18, 32'h0);
		@(posedge clk);
		out_cmd[0] <= ~out_cmd[0];
		repeat (4) @(posedge clk);
		rd(8'h18, 32'h0001_0000);
		// fault drives the output off so the restore window sees no edge
		@(posedge clk);
		comm <= '{1'b1, 1'b0};
		repeat (120) @(posedge clk);
		do_reset;
		repeat (2 * NCH + 4) @(posedge clk);
		rd(8'h40, 32'd1002);
		wr(8'h14, 32'h1);
		rd(8'h40, 32'h0);
		@(posedge clk);
		comm <= '{1'b0, 1'b0};
		out_cmd <= 8'h00;
		$display("test count done");
	endtask : t_count

	task automatic t_inputs;
		int k;
		for (int s = 0; s < 4; s++) begin
			wr(8'h00, 32'h1100 * s);
			din_pin[0] <= 1'b1;
			repeat (FT[s] - 1) @(posedge clk);
			din_pin[0] <= 1'b0;
			repeat (FT[s] + 6) @(posedge clk);
			#1 chk(din_state[0], 1'b0);
			@(posedge clk);
			din_pin[0] <= 1'b1;
			for (k = 0; k < FT[s] + 8 && din_state[0] !== 1'b1; k++) begin
				@(posedge clk);
				#1;
			end
			chk(k >= FT[s] && din_state[0] === 1'b1, 1'b1);
			if (din_state[0] !== 1'b1)
				results();
			@(posedge clk);
			din_pin[0] <= 1'b0;
			for (k = 0; k < ET[s] + FT[s] + 8 && din_state[0] === 1'b1; k++) begin
				@(posedge clk);
				#1;
			end
			chk(k >= ET[s] - 1 && din_state[0] === 1'b0, 1'b1);
			if (din_state[0] !== 1'b0)
				results();
			// the low state is stretched too before the next pulse
			repeat (ET[s] + 4) @(posedge clk);
		end
		$display("test inputs done");
	endtask : t_inputs

	initial begin
		do_reset;
		repeat (2 * NCH + 2) @(posedge clk);
		t_outputs;
		t_errors;
		t_count;
		t_inputs;
		results;
	end
endmodule : dioc_supervisor_tb
`default_nettype wire
